// file: timer_pkg.sv
// Function
// - Sixteen-bit counter readable by software as separate low and high byte registers.
// - Flag carry out of the low byte and overflow of the full count.
// - Both overflow flags live in the timer interrupt flag register.
// - Prescaler divides its input by 1, 2, 4 or 8 from a two-bit field.
// - Two-bit source field picks oscillator over twelve, external input, or stop.
// - External input sampled at two phases per machine cycle; low then high counts.
// - Late-phase detection advances the prescaler two machine cycles later.
// - Early-phase detection advances the prescaler in the very next machine cycle.
// - Writing clock source or prescale selection clears the prescaler.
// - Software cannot clear the counter; only chip or external reset does.
// - External timer reset acts only while its enable bit is set.
// - Chip reset and enabled external reset clear prescaler and counter.
// - One interrupt request, raised by low overflow, full overflow, both or neither.
`default_nettype none

package timer_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W             = 3;
    localparam int          DATA_W             = 8;
    localparam int          COUNT_W            = 16;
    localparam logic [2:0]  ADDR_COUNT_LOW     = 3'h0;
    localparam logic [2:0]  ADDR_COUNT_HIGH    = 3'h1;
    localparam logic [2:0]  ADDR_TIMER_CONTROL = 3'h2;
    localparam logic [2:0]  ADDR_TIMER_IRQ_FLAG = 3'h3;
    localparam logic [2:0]  ADDR_IRQ_MASK      = 3'h4;

    // ------------------------------------------------------------------
    // Field layouts and selections
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] irq_sel;
        logic       rsvd;
        logic       ext_reset_enable;
        logic       prescale_sel_bit1;
        logic       prescale_sel_bit0;
        logic       clock_source_sel_bit1;
        logic       clock_source_sel_bit0;
    } timer_ctrl_t;

    typedef struct packed {
        logic [5:0] rsvd;
        logic       full_overflow_flag;
        logic       low_byte_overflow_flag;
    } irq_flags_t;

    localparam logic [1:0]  SRC_STOP           = 2'h0;
    localparam logic [1:0]  SRC_OSC_DIV12      = 2'h1;
    localparam logic [1:0]  SRC_EXTERNAL       = 2'h2;
    localparam logic [1:0]  DIV_BY_1           = 2'h0;
    localparam logic [1:0]  DIV_BY_2           = 2'h1;
    localparam logic [1:0]  DIV_BY_4           = 2'h2;
    localparam logic [1:0]  IRQ_SEL_NONE       = 2'h0;
    localparam logic [1:0]  IRQ_SEL_LOW        = 2'h1;
    localparam logic [1:0]  IRQ_SEL_FULL       = 2'h2;
    localparam logic [1:0]  IRQ_SEL_BOTH       = 2'h3;

    localparam timer_ctrl_t CTRL_RESET         = 8'h00;
    localparam irq_flags_t  FLAGS_RESET        = 8'h00;
    localparam irq_flags_t  MASK_RESET         = 8'h00;

    // ------------------------------------------------------------------
    // Machine cycle timing
    // ------------------------------------------------------------------
    localparam int          MC_PHASES          = 12;
    localparam logic [3:0]  PH_ADVANCE         = 4'h0;
    localparam logic [3:0]  PH_EARLY_SAMPLE    = 4'h2;
    localparam logic [3:0]  PH_LATE_SAMPLE     = 4'h8;
    localparam logic [3:0]  PH_LAST            = 4'hb;
    localparam logic [7:0]  LOW_BYTE_ONES      = 8'hff;
    localparam logic [15:0] COUNT_ONES         = 16'hffff;

endpackage

`default_nettype wire

// file: sync_2ff.sv
`timescale 1ns/10ps
`default_nettype none

module sync_2ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_mclk,     // System clock.
    input  wire logic             i_sys_rst,  // Synchronous reset, active high.
    input  wire logic [WIDTH-1:0] i_async,    // Inputs from outside the clock domain.
    output var  logic [WIDTH-1:0] o_sync      // Synchronised copies.
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule

`default_nettype wire

// file: prescaled_timebase_counter.sv
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module prescaled_timebase_counter
    import timer_pkg::*;
#(
    parameter int PRESC_W = 3
) (
    input  wire logic              i_mclk,                  // System clock, 100 MHz.
    input  wire logic              i_sys_rst,               // Synchronous chip reset, active high.
    input  wire logic [ADDR_W-1:0] i_addr,                  // Register address.
    input  wire logic [DATA_W-1:0] i_wdata,                 // Register write data.
    input  wire logic              i_wr,                    // Write strobe.
    input  wire logic              i_rd,                    // Read strobe.
    output var  logic [DATA_W-1:0] o_rdata,                 // Read data, one cycle after the strobe.
    input  wire logic              i_ext_count_input,       // External count pin.
    input  wire logic              i_ext_timer_reset_input, // External timer reset pin, active high.
    output logic                   o_irq                    // Level interrupt request.
);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    logic [1:0] pins_sync;
    logic       ext_count_s;
    logic       ext_reset_s;

    sync_2ff #(
        .WIDTH (2)
    ) u_pin_sync (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_ext_timer_reset_input, i_ext_count_input}),
        .o_sync    (pins_sync)
    );

    assign ext_count_s = pins_sync[0];
    assign ext_reset_s = pins_sync[1];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    timer_ctrl_t        timer_control_reg;
    irq_flags_t         timer_irq_flag_reg;
    irq_flags_t         irq_mask_reg;
    logic [COUNT_W-1:0] count;
    logic [PRESC_W-1:0] presc_cnt;
    logic [3:0]         phase;
    logic               last_sample;
    logic               adv_pending_late;
    logic               adv_fire;
    logic               early_seen;
    logic               late_seen;

    // ------------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------------
    wire ctrl_write  = i_wr && (i_addr == ADDR_TIMER_CONTROL);
    wire mask_write  = i_wr && (i_addr == ADDR_IRQ_MASK);
    wire flags_read  = i_rd && (i_addr == ADDR_TIMER_IRQ_FLAG);

    wire [1:0] clock_source = {timer_control_reg.clock_source_sel_bit1,
                               timer_control_reg.clock_source_sel_bit0};
    wire [1:0] prescale     = {timer_control_reg.prescale_sel_bit1,
                               timer_control_reg.prescale_sel_bit0};

    // ------------------------------------------------------------------
    // Machine cycle phases and external sampling
    // ------------------------------------------------------------------
    // The system clock stands in for the oscillator, so one machine cycle
    // spans twelve clocks and each phase is one clock.
    wire cycle_end      = (phase == PH_LAST);
    wire at_advance     = (phase == PH_ADVANCE);
    wire at_early       = (phase == PH_EARLY_SAMPLE);
    wire at_late        = (phase == PH_LATE_SAMPLE);
    wire sample_now     = at_early || at_late;
    wire rising_seen    = sample_now && !last_sample && ext_count_s;
    wire early_hit      = rising_seen && at_early;
    wire late_hit       = rising_seen && at_late;
    wire ext_advance    = adv_fire && at_advance;

    wire [3:0] next_phase = cycle_end ? PH_ADVANCE : phase + 4'h1;

    // Detections are held until the machine cycle ends. An early one fires in
    // the next machine cycle, a late one waits one more in the pending stage.
    wire next_early_seen = !cycle_end && (early_seen || early_hit);
    wire next_late_seen  = !cycle_end && (late_seen || late_hit);
    wire next_adv_fire   = cycle_end ? (early_seen || adv_pending_late) : adv_fire;
    wire next_pending    = cycle_end ? late_seen : adv_pending_late;

    // ------------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------------
    wire presc_in = (clock_source == SRC_OSC_DIV12) ? at_advance :
                    (clock_source == SRC_EXTERNAL)  ? ext_advance : 1'b0;

    wire [PRESC_W-1:0] div_mask = (prescale == DIV_BY_1) ? PRESC_W'(0) :
                                  (prescale == DIV_BY_2) ? PRESC_W'(1) :
                                  (prescale == DIV_BY_4) ? PRESC_W'(3) : PRESC_W'(7);

    wire count_tick     = presc_in && ((presc_cnt & div_mask) == div_mask);
    wire ext_reset_hit  = timer_control_reg.ext_reset_enable && ext_reset_s;
    wire presc_clear    = ext_reset_hit || ctrl_write;

    wire [PRESC_W-1:0] next_presc_cnt = presc_clear ? '0 :
                                        presc_in    ? presc_cnt + PRESC_W'(1) : presc_cnt;

    // Counter has no software write path; only the resets clear it.
    wire [COUNT_W-1:0] next_count = ext_reset_hit ? '0 :
                                    count_tick    ? count + COUNT_W'(1) : count;

    // ------------------------------------------------------------------
    // Overflow flags and interrupt
    // ------------------------------------------------------------------
    wire low_ovf_set  = count_tick && !ext_reset_hit && (count[7:0] == LOW_BYTE_ONES);
    wire full_ovf_set = count_tick && !ext_reset_hit && (count == COUNT_ONES);

    irq_flags_t flag_set;
    irq_flags_t next_flags;

    assign flag_set   = {6'h00, full_ovf_set, low_ovf_set};
    // A read clears the flags, but an overflow in that same cycle survives.
    assign next_flags = (flags_read ? FLAGS_RESET : timer_irq_flag_reg) | flag_set;

    wire [1:0] irq_src_en = (timer_control_reg.irq_sel == IRQ_SEL_LOW)  ? 2'h1 :
                            (timer_control_reg.irq_sel == IRQ_SEL_FULL) ? 2'h2 :
                            (timer_control_reg.irq_sel == IRQ_SEL_BOTH) ? 2'h3 : 2'h0;

    wire [1:0] irq_active = {timer_irq_flag_reg.full_overflow_flag,
                             timer_irq_flag_reg.low_byte_overflow_flag}
                            & {irq_mask_reg.full_overflow_flag, irq_mask_reg.low_byte_overflow_flag}
                            & irq_src_en;

    assign o_irq = |irq_active;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    timer_ctrl_t ctrl_wr_value;

    assign ctrl_wr_value      = timer_ctrl_t'(i_wdata);

    wire [DATA_W-1:0] read_mux =
        (i_addr == ADDR_COUNT_LOW)      ? count[7:0] :
        (i_addr == ADDR_COUNT_HIGH)     ? count[15:8] :
        (i_addr == ADDR_TIMER_CONTROL)  ? DATA_W'(timer_control_reg) :
        (i_addr == ADDR_TIMER_IRQ_FLAG) ? DATA_W'(timer_irq_flag_reg) :
        (i_addr == ADDR_IRQ_MASK)       ? DATA_W'(irq_mask_reg) : 8'h00;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            phase            <= PH_ADVANCE;
            last_sample      <= 1'b0;
            adv_pending_late <= 1'b0;
            adv_fire         <= 1'b0;
            early_seen       <= 1'b0;
            late_seen        <= 1'b0;
        end else begin
            phase            <= next_phase;
            last_sample      <= sample_now ? ext_count_s : last_sample;
            adv_pending_late <= next_pending;
            early_seen       <= next_early_seen;
            late_seen        <= next_late_seen;
            adv_fire         <= cycle_end ? next_adv_fire : (adv_fire && !at_advance);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            count     <= '0;
            presc_cnt <= '0;
        end else begin
            count     <= next_count;
            presc_cnt <= next_presc_cnt;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            timer_control_reg  <= CTRL_RESET;
            irq_mask_reg       <= MASK_RESET;
            timer_irq_flag_reg <= FLAGS_RESET;
        end else begin
            if (ctrl_write) begin
                timer_control_reg      <= ctrl_wr_value;
                timer_control_reg.rsvd <= 1'b0;
            end
            if (mask_write) begin
                irq_mask_reg      <= irq_flags_t'(i_wdata);
                irq_mask_reg.rsvd <= 6'h00;
            end
            timer_irq_flag_reg <= next_flags;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? read_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    count_wrap_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (count_tick && !ext_reset_hit && count == COUNT_ONES) |=> (count == 16'h0000)
    ) else $error("Counter did not wrap to zero.");

    low_ovf_flag_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (low_ovf_set) |=> timer_irq_flag_reg.low_byte_overflow_flag
    ) else $error("Low byte overflow flag not set.");

    full_ovf_flag_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (count_tick && !ext_reset_hit && count == COUNT_ONES)
        |=> (timer_irq_flag_reg.full_overflow_flag && timer_irq_flag_reg.low_byte_overflow_flag)
    ) else $error("Full overflow did not set both flags.");

    flag_hold_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (timer_irq_flag_reg.full_overflow_flag && !flags_read)
        |=> timer_irq_flag_reg.full_overflow_flag
    ) else $error("Overflow flag dropped without a read.");

    ext_reset_clear_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (timer_control_reg.ext_reset_enable && ext_reset_s)
        |=> (count == 16'h0000 && presc_cnt == '0)
    ) else $error("External reset did not clear counter and prescaler.");

    ext_reset_ignored_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (!timer_control_reg.ext_reset_enable && count_tick)
        |=> (count == $past(count) + 16'h0001)
    ) else $error("Disabled external reset disturbed counting.");

    presc_clear_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        ctrl_write |=> (presc_cnt == '0)
    ) else $error("Control write did not clear the prescaler.");

    stop_hold_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (clock_source == SRC_STOP && !ext_reset_hit) |=> (count == $past(count))
    ) else $error("Counter moved with the clock stopped.");

    early_adv_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        early_hit |-> ##10 ext_advance
    ) else $error("Early detection did not advance in the next cycle.");

    late_adv_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        late_hit |-> (!ext_advance) [*4] ##13 ext_advance
    ) else $error("Late detection did not advance two cycles later.");

    div_ratio_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (count_tick && prescale == DIV_BY_2 && !presc_clear) |=> !presc_cnt[0]
    ) else $error("Divide by two did not restart its pair after a tick.");

    irq_read_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (flags_read && !low_ovf_set && !full_ovf_set) |=> !o_irq
    ) else $error("Interrupt stayed high after flags were read.");

    read_low_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (i_rd && i_addr == ADDR_COUNT_LOW) |=> (o_rdata == $past(count[7:0]))
    ) else $error("Low byte read returned the wrong value.");

endmodule

`default_nettype wire

// file: ext_pin_source.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// Sources of the external count pin and the external timer reset pin
// ----------------------------------------------------------------------
module ext_pin_source (
    input  wire logic i_mclk,                  // System clock, used only to pace the pins.
    output var  logic o_ext_count_input,       // External count pin, idles low.
    output var  logic o_ext_timer_reset_input  // External timer reset pin, active high.
);
    initial begin
        o_ext_count_input = 1'b0;
        o_ext_timer_reset_input = 1'b0;
    end

    // Each level lasts at least one machine cycle, so both samples see it.
    task automatic send_edges(input int n, input int half);
        for (int i = 0; i < n; i++) begin
            repeat (half) @(posedge i_mclk);
            o_ext_count_input <= 1'b1;
            repeat (half) @(posedge i_mclk);
            o_ext_count_input <= 1'b0;
        end
    endtask

    task automatic set_reset(input logic level);
        o_ext_timer_reset_input <= level;
        @(posedge i_mclk);
    endtask
endmodule

`default_nettype wire

// file: prescaled_timebase_counter_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module prescaled_timebase_counter_tb_top;
    import timer_pkg::*;

    localparam int LIMIT = 20000;

    logic              mclk;
    logic              sys_rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic              cnt_pin;
    logic              trst_pin;
    logic              irq;
    logic [7:0]        v0;
    logic [7:0]        v1;
    int                n_errors;
    int                check_count;
    int                cycles;
    int                k;
    int                m;
    int unsigned       rnd;

    prescaled_timebase_counter #(.PRESC_W(3)) dut (
        .i_mclk                  (mclk),
        .i_sys_rst               (sys_rst),
        .i_addr                  (addr),
        .i_wdata                 (wdata),
        .i_wr                    (wr),
        .i_rd                    (rd),
        .o_rdata                 (rdata),
        .i_ext_count_input       (cnt_pin),
        .i_ext_timer_reset_input (trst_pin),
        .o_irq                   (irq)
    );

    ext_pin_source pins (
        .i_mclk                  (mclk),
        .o_ext_count_input       (cnt_pin),
        .o_ext_timer_reset_input (trst_pin)
    );

    // ------------------------------------------------------------------
    // Clock, timeout and common tasks
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            test_done();
        end
    end

    task automatic test_done();
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Strobes are cleared before a gap cycle, so no signal is set twice in a step.
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge mclk);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    function automatic logic [7:0] ctrl(input logic [1:0] src, input logic [1:0] div,
                                         input logic [1:0] isel, input logic ere);
        return {isel, 1'b0, ere, div, src};
    endfunction

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        n_errors = 0;
        check_count = 0;
        cycles = 0;
        rnd = $urandom(22);
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        for (int a = 0; a < 8; a++) begin
            rd_reg(3'(a), v0);
            check(v0, 8'h00);
        end
        // Stopped sources: software writes must not move the count or flags.
        for (int s = 0; s < 4; s += 3) begin
            wr_reg(ADDR_TIMER_CONTROL, ctrl(2'(s), DIV_BY_1, IRQ_SEL_NONE, 1'b0));
            wr_reg(ADDR_COUNT_LOW, 8'h5a);
            wr_reg(ADDR_COUNT_HIGH, 8'ha5);
            wr_reg(ADDR_TIMER_IRQ_FLAG, 8'h03);
            wait_cyc(100);
            rd_reg(ADDR_COUNT_LOW, v0);
            check(v0, 8'h00);
            rd_reg(ADDR_COUNT_HIGH, v0);
            check(v0, 8'h00);
            rd_reg(ADDR_TIMER_IRQ_FLAG, v0);
            check(v0, 8'h00);
        end
        wr_reg(ADDR_TIMER_CONTROL, 8'hff);
        rd_reg(ADDR_TIMER_CONTROL, v0);
        check(v0, 8'hdf);
        wr_reg(ADDR_IRQ_MASK, 8'hff);
        rd_reg(ADDR_IRQ_MASK, v0);
        check(v0, 8'h03);
        // Oscillator source: a window of 96*m clocks holds 8*m prescaler inputs.
        for (int d = 0; d < 4; d++) begin
            m = 1 + ($urandom % 3);
            wr_reg(ADDR_TIMER_CONTROL, ctrl(SRC_OSC_DIV12, 2'(d), IRQ_SEL_NONE, 1'b0));
            rd_reg(ADDR_COUNT_LOW, v0);
            wait_cyc(96 * m - 2);
            rd_reg(ADDR_COUNT_LOW, v1);
            check(v1 - v0, 8'((8 * m) >> d));
        end
        // Rewriting control every 46 clocks keeps a divide-by-8 prescaler from wrapping.
        rd_reg(ADDR_COUNT_LOW, v0);
        repeat (10) begin
            wait_cyc(44);
            wr_reg(ADDR_TIMER_CONTROL, ctrl(SRC_OSC_DIV12, 2'h3, IRQ_SEL_NONE, 1'b0));
        end
        rd_reg(ADDR_COUNT_LOW, v1);
        check(v1 - v0, 8'h00);
        // External source with random edge counts and pacing.
        for (int d = 0; d < 4; d++) begin
            k = 1 + ($urandom % 20);
            wr_reg(ADDR_TIMER_CONTROL, ctrl(SRC_EXTERNAL, 2'(d), IRQ_SEL_NONE, 1'b0));
            rd_reg(ADDR_COUNT_LOW, v0);
            pins.send_edges(k, 12 + ($urandom % 13));
            wait_cyc(40);
            rd_reg(ADDR_COUNT_LOW, v1);
            check(v1 - v0, 8'(k >> d));
        end
        // Low-byte overflow, interrupt selection and masking.
        rd_reg(ADDR_TIMER_IRQ_FLAG, v0);
        wr_reg(ADDR_TIMER_CONTROL, ctrl(SRC_OSC_DIV12, DIV_BY_1, IRQ_SEL_LOW, 1'b0));
        wait_cyc(256 * 12 + 30);
        check({7'h00, irq}, 8'h01);
        wr_reg(ADDR_TIMER_CONTROL, ctrl(SRC_OSC_DIV12, DIV_BY_1, IRQ_SEL_FULL, 1'b0));
        check({7'h00, irq}, 8'h00);
        wr_reg(ADDR_TIMER_CONTROL, ctrl(SRC_OSC_DIV12, DIV_BY_1, IRQ_SEL_BOTH, 1'b0));
        check({7'h00, irq}, 8'h01);
        wr_reg(ADDR_TIMER_CONTROL, ctrl(SRC_OSC_DIV12, DIV_BY_1, IRQ_SEL_NONE, 1'b0));
        check({7'h00, irq}, 8'h00);
        wr_reg(ADDR_TIMER_CONTROL, ctrl(SRC_OSC_DIV12, DIV_BY_1, IRQ_SEL_LOW, 1'b0));
        wr_reg(ADDR_IRQ_MASK, 8'h02);
        check({7'h00, irq}, 8'h00);
        wr_reg(ADDR_IRQ_MASK, 8'h03);
        check({7'h00, irq}, 8'h01);
        rd_reg(ADDR_TIMER_IRQ_FLAG, v0);
        check(v0, 8'h01);
        check({7'h00, irq}, 8'h00);
        // External timer reset: ignored when disabled, clears when enabled.
        wr_reg(ADDR_TIMER_CONTROL, ctrl(SRC_STOP, DIV_BY_1, IRQ_SEL_NONE, 1'b0));
        rd_reg(ADDR_COUNT_HIGH, v0);
        check({7'h00, v0 != 8'h00}, 8'h01);
        pins.set_reset(1'b1);
        wait_cyc(10);
        pins.set_reset(1'b0);
        rd_reg(ADDR_COUNT_HIGH, v1);
        check(v1, v0);
        wr_reg(ADDR_TIMER_CONTROL, ctrl(SRC_OSC_DIV12, DIV_BY_1, IRQ_SEL_NONE, 1'b1));
        pins.set_reset(1'b1);
        wait_cyc(40);
        rd_reg(ADDR_COUNT_LOW, v0);
        check(v0, 8'h00);
        rd_reg(ADDR_COUNT_HIGH, v0);
        check(v0, 8'h00);
        pins.set_reset(1'b0);
        // Chip reset in mid-run.
        wait_cyc(50);
        sys_rst <= 1'b1;
        wait_cyc(3);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd_reg(ADDR_COUNT_LOW, v0);
        check(v0, 8'h00);
        rd_reg(ADDR_TIMER_CONTROL, v0);
        check(v0, CTRL_RESET);
        test_done();
    end
endmodule

`default_nettype wire
